// ===== osc_param_block.sv
// Sample-loop and wavetable oscillator: parameter block, pointer engine, interpolation
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module osc_param_block
    import osc_param_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    // Register port
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // System settings
    input  wire logic [5:0]  osc_index_in,
    input  wire logic        bus_master_enable_in,
    // Envelope engine flag update
    input  wire logic        env_flags_we_in,
    input  wire logic [1:0]  env_flags_in,
    // Sample stream
    input  wire logic        sample_tick_in,
    input  wire logic [15:0] sample_now_in,
    input  wire logic [15:0] sample_next_in,
    output logic      [23:0] wave_addr_out,
    output logic             host_memory_fetch_enable_out,
    output logic      [15:0] sample_out,
    output logic             sample_valid_out,
    // Oscillator mode
    output logic             osc_active_out,
    output logic             sample_width16_out,
    output logic             wavetable_mode_out,
    output logic             half_rate_out,
    output logic      [3:0]  filter_q_out,
    output logic      [1:0]  envelope_kind_select_out,
    output logic      [1:0]  effect_primary_out,
    output logic      [1:0]  effect_secondary_out,
    output logic             effect_dual_out
);

    typedef struct packed {
        logic [REG_BYTES-1:0][7:0] bytes;
        logic [7:0]                rd_data;
        logic                      rd_from_store;
        logic [15:0]               now_q;
        logic [15:0]               next_q;
        logic [15:0]               frac_q;
        logic                      load;
        logic [15:0]               sample;
        logic                      valid;
        logic [7:0]                smooth;
    } osc_state_t;

    osc_state_t state;
    osc_state_t next_state;

    logic [7:0] store_rdata;
    logic       store_wr;

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    logic [7:0]  ctl;
    logic [1:0]  osc_type;
    logic        osc_on;
    logic        wt_mode;
    logic        loop_mode;
    logic [15:0] ptr;
    logic [31:0] pos;
    logic [31:0] step;
    logic [15:0] end_loop;
    logic [15:0] end_table;
    logic [15:0] loop_len;
    logic [15:0] tsize;
    logic [15:0] ispan;
    logic        automatic_table_advance;

    assign ctl       = state.bytes[OFS_CONTROL];
    assign osc_type  = ctl[7:6];
    assign osc_on    = (ctl != BYTE_RESET);
    assign wt_mode   = osc_on && (osc_type == TYPE_EXTENDED)
                       && (state.bytes[OFS_FREQ_HI][7:4] == OPCODE_WAVETABLE);
    assign loop_mode = osc_on && ((osc_type == TYPE_PCM8) || (osc_type == TYPE_PCM16));
    assign ptr       = {state.bytes[OFS_PTR_MID], state.bytes[OFS_PTR_LO]};
    assign pos       = {ptr, state.bytes[OFS_PHASE], state.smooth};
    assign end_loop  = {state.bytes[OFS_END_HI], state.bytes[OFS_END_LO][7:2], 2'b00};
    assign loop_len  = {state.bytes[OFS_LEN_HI], state.bytes[OFS_LEN_LO]};
    assign tsize     = {6'h00, table_span(state.bytes[OFS_LEN_LO][1:0])};
    assign ispan     = {6'h00, table_span(state.bytes[OFS_END_LO][3:2])};
    assign automatic_table_advance       = state.bytes[OFS_END_LO][END_AWS_BIT];
    assign end_table = {state.bytes[OFS_END_HI], state.bytes[OFS_END_LO][7:5], 5'h00}
                       & ~(ispan - 16'h0001);

    // Frequency lines up with the lowest smoothing bit of the position
    always_comb
    begin
        if (wt_mode)
            step = {14'h0000, state.bytes[OFS_FREQ_HI][3:0],
                    state.bytes[OFS_FREQ_MID], state.bytes[OFS_FREQ_LO][7:2]};
        else
            step = {{10{state.bytes[OFS_FREQ_HI][7]}}, state.bytes[OFS_FREQ_HI],
                    state.bytes[OFS_FREQ_MID], state.bytes[OFS_FREQ_LO][7:2]};
    end

    // ------------------------------------------------------------
    // Pointer engine
    // ------------------------------------------------------------
    logic [31:0] sum;
    logic [15:0] new_ptr;
    logic [15:0] offset;
    logic [15:0] new_offset;
    logic [15:0] base;
    logic [15:0] new_base;

    always_comb
    begin
        sum        = pos + step;
        new_ptr    = sum[31:16];
        offset     = ptr & (tsize - 16'h0001);
        base       = ptr & ~(tsize - 16'h0001);
        new_offset = offset + (new_ptr - ptr);
        new_base   = base;
        if (wt_mode)
        begin
            if (new_offset >= tsize)
            begin
                // Table end reached: decide which table plays next
                new_offset = new_offset - tsize;
                if (!automatic_table_advance)
                    new_base = end_table;
                else if (base != end_table)
                    new_base = base + ispan;
                else
                    new_base = base;
            end
            new_ptr = new_base + new_offset;
        end
        else if (!step[31])
        begin
            if ((ptr <= end_loop) && (new_ptr > end_loop))
                new_ptr = new_ptr - loop_len;
        end
        else
        begin
            // Reverse play loops back the other way across the endpoint
            if ((ptr >= end_loop) && (new_ptr < end_loop))
                new_ptr = new_ptr + loop_len;
        end
    end

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    logic advance;

    assign advance  = sample_tick_in && (wt_mode || loop_mode);
    assign store_wr = reg_wr_in && (reg_addr_in >= OFS_RAM_FIRST)
                      && (reg_addr_in < 5'(BLOCK_BYTES));

    always_comb
    begin
        next_state       = state;
        next_state.load  = 1'b0;
        next_state.valid = state.load;
        if (advance)
        begin
            // Latch samples and fraction before the pointer moves on
            next_state.now_q  = sample_now_in;
            next_state.next_q = sample_next_in;
            next_state.frac_q = {state.bytes[OFS_PHASE], state.smooth};
            next_state.load   = 1'b1;
            next_state.bytes[OFS_PTR_LO]  = new_ptr[7:0];
            next_state.bytes[OFS_PTR_MID] = new_ptr[15:8];
            next_state.bytes[OFS_PHASE]   = sum[15:8];
            next_state.smooth             = sum[7:0];
        end
        if (env_flags_we_in)
            next_state.bytes[OFS_END_LO][1:0] = env_flags_in;
        // Host writes land last so they override the engine
        if (reg_wr_in && (reg_addr_in < OFS_RAM_FIRST))
        begin
            next_state.bytes[reg_addr_in[3:0]] = reg_wdata_in;
            if (reg_addr_in == OFS_PHASE)
                next_state.smooth = BYTE_RESET;
        end
        next_state.rd_from_store = reg_rd_in && (reg_addr_in >= OFS_RAM_FIRST)
                                   && (reg_addr_in < 5'(BLOCK_BYTES));
        if (reg_rd_in && (reg_addr_in < OFS_RAM_FIRST))
            next_state.rd_data = state.bytes[reg_addr_in[3:0]];
        else
            next_state.rd_data = BYTE_RESET;
        if (state.load)
            next_state.sample = interp(state.now_q, state.next_q, state.frac_q, ctl[7:6]);
    end

    // Piecewise linear blend; narrow samples sit in the low byte
    function automatic logic [15:0] interp(input logic [15:0] a_raw,
                                           input logic [15:0] b_raw,
                                           input logic [15:0] frac,
                                           input logic [1:0]  kind);
        logic signed [16:0] a;
        logic signed [16:0] b;
        logic signed [16:0] diff;
        logic signed [33:0] prod;
        logic signed [17:0] res;
        a    = (kind == TYPE_PCM8) ? {a_raw[7], a_raw[7:0], 8'h00} : {a_raw[15], a_raw};
        b    = (kind == TYPE_PCM8) ? {b_raw[7], b_raw[7:0], 8'h00} : {b_raw[15], b_raw};
        diff = b - a;
        prod = diff * $signed({1'b0, frac});
        res  = {a[16], a} + prod[33:16];
        interp = res[15:0];
    endfunction : interp

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            state <= '0;
        else if (ce_in)
            state <= next_state;
    end

    osc_param_store u_store (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .wr_en_in    (store_wr),
        .wr_addr_in  (4'(reg_addr_in - OFS_RAM_FIRST)),
        .wr_data_in  (reg_wdata_in),
        .rd_addr_in  (4'(reg_addr_in - OFS_RAM_FIRST)),
        .rd_data_out (store_rdata)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [1:0] eff_ch;

    assign eff_ch = state.bytes[OFS_EFFECT][7:6];

    assign reg_rdata_out  = state.rd_from_store ? store_rdata : state.rd_data;
    assign wave_addr_out  = {state.bytes[OFS_PTR_HI], ptr};
    assign host_memory_fetch_enable_out = bus_master_enable_in
                                          && state.bytes[OFS_PTR_HI][PTR_HOST_BIT];
    assign sample_out         = osc_on ? state.sample : 16'h0000;
    assign sample_valid_out   = state.valid && osc_on;
    assign osc_active_out     = wt_mode || loop_mode;
    assign sample_width16_out = (osc_type == TYPE_PCM16);
    assign wavetable_mode_out = wt_mode;
    assign half_rate_out      = ctl[CTL_HALF_BIT] && (osc_index_in < HALF_RATE_LIMIT);
    assign filter_q_out       = ctl[3:0];
    assign envelope_kind_select_out = state.bytes[OFS_FREQ_LO][1:0];
    assign effect_primary_out   = eff_ch;
    assign effect_secondary_out = eff_ch + 2'h1;
    assign effect_dual_out      = osc_on && ctl[CTL_DUAL_BIT];

endmodule : osc_param_block
`default_nettype wire

// ===== osc_param_pkg.sv
// Constants and types for the per-oscillator parameter block
// Overview of operation
// - Each oscillator owns a 24-byte host-written parameter block; control byte at offset 0.
// - An all-zero control byte stops the oscillator completely.
// - Type bits 6-7: 01 8-bit samples, 10 16-bit samples, 11 extended opcode.
// - With type 11, frequency high bits 7-4 pick the opcode; 0100 is wavetable.
// - Control bits 0-3 set the variable filter quality factor.
// - Control bit 4 feeds the chosen effects channel and the next, wrapping 3 to 0.
// - Control bit 5 halves oscillators 0-47; 48-63 always run full rate.
// - Frequency low bits 0-1 pick envelope: amplitude, tremolo, filter, pan.
// - Sample loop frequency is 22-bit signed; negative plays backwards.
// - Wavetable frequency is 18-bit unsigned, top four from frequency high bits 0-3.
// - Each output sample adds frequency to phase and 16-bit pointer.
// - Output interpolates current and next sample using phase plus eight extra bits.
// - Pointer high byte drives address 16-23 and never changes during the note.
// - With bus mastering on, pointer high bit 7 sends fetches to host memory.
// - Middle and low pointer bytes form a 16-bit sample index.
// - Endpoint low bits 0-1 hold envelope state, or tremolo enable and polarity.
// - Endpoint low bits 2-3 set wavetable spacing 64, 128, 256 or 512.
// - Table advance off: loop table, jump to endpoint table after its last sample.
// - Table advance on: step through every table up to the endpoint, then loop.
// - Sample loop subtracts loop length from pointer after playing the endpoint.
// - Sample loop endpoint compares only low bits 2-7, so ends on multiples of four.
// - Loop length low bits 0-1 set wavetable size; software writes other bits zero.
package osc_param_pkg;

    // ------------------------------------------------------------
    // Block layout
    // ------------------------------------------------------------
    localparam int unsigned BLOCK_BYTES = 24;
    localparam int unsigned REG_BYTES   = 13;
    localparam int unsigned RAM_BYTES   = 11;

    localparam logic [4:0] OFS_CONTROL   = 5'h00;
    localparam logic [4:0] OFS_FREQ_LO   = 5'h01;
    localparam logic [4:0] OFS_FREQ_MID  = 5'h02;
    localparam logic [4:0] OFS_FREQ_HI   = 5'h03;
    localparam logic [4:0] OFS_PHASE     = 5'h04;
    localparam logic [4:0] OFS_PTR_HI    = 5'h05;
    localparam logic [4:0] OFS_PTR_LO    = 5'h06;
    localparam logic [4:0] OFS_PTR_MID   = 5'h07;
    localparam logic [4:0] OFS_END_LO    = 5'h08;
    localparam logic [4:0] OFS_END_HI    = 5'h09;
    localparam logic [4:0] OFS_LEN_LO    = 5'h0A;
    localparam logic [4:0] OFS_LEN_HI    = 5'h0B;
    localparam logic [4:0] OFS_EFFECT    = 5'h0C;
    localparam logic [4:0] OFS_RAM_FIRST = 5'h0D;

    localparam logic [7:0] BYTE_RESET    = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTL_DUAL_BIT  = 4;
    localparam int unsigned CTL_HALF_BIT  = 5;
    localparam int unsigned END_AWS_BIT   = 4;
    localparam int unsigned PTR_HOST_BIT  = 7;

    localparam logic [1:0] TYPE_PCM8     = 2'h1;
    localparam logic [1:0] TYPE_PCM16    = 2'h2;
    localparam logic [1:0] TYPE_EXTENDED = 2'h3;
    localparam logic [3:0] OPCODE_WAVETABLE = 4'h4;

    localparam logic [5:0] HALF_RATE_LIMIT = 6'h30;
    localparam logic [9:0] TABLE_UNIT      = 10'h040;

    typedef enum logic [1:0] {
        ENV_AMPLITUDE = 2'b00,
        ENV_TREMOLO   = 2'b01,
        ENV_FILTER    = 2'b10,
        ENV_PAN       = 2'b11
    } envelope_kind_t;

    function automatic logic [9:0] table_span(input logic [1:0] code);
        table_span = TABLE_UNIT << code;
    endfunction : table_span

endpackage : osc_param_pkg

// ===== osc_param_store.sv
// Byte store for the upper parameter bytes that the engine does not use
`timescale 1ns/1ps
`default_nettype none
module osc_param_store
    import osc_param_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       ce_in,
    // Access
    input  wire logic       wr_en_in,
    input  wire logic [3:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [3:0] rd_addr_in,
    output logic      [7:0] rd_data_out
);

    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] mem;
        logic [7:0]                rd_data;
    } store_state_t;

    store_state_t state;
    store_state_t next_state;

    always_comb
    begin
        next_state = state;
        if (rd_addr_in < 4'(RAM_BYTES))
            next_state.rd_data = state.mem[rd_addr_in];
        else
            next_state.rd_data = BYTE_RESET;
        if (wr_en_in && (wr_addr_in < 4'(RAM_BYTES)))
            next_state.mem[wr_addr_in] = wr_data_in;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
            state <= '0;
        else if (ce_in)
            state <= next_state;
    end

    assign rd_data_out = state.rd_data;

endmodule : osc_param_store
`default_nettype wire

// ===== wave_mem_model.sv
// Wave sample memory seen by the oscillator's fetch address
`timescale 1ns/1ps
`default_nettype none
module wave_mem_model
(
    // Fetch address
    input  wire logic [23:0] addr_in,
    // Sample data
    output logic      [15:0] now_out,
    output logic      [15:0] next_out
);
    // ----------
    // Contents
    // ----------
    // A ramp keeps neighbouring samples 0x100 apart, so interpolation slips show clearly.
    // Only index bits 0-6 are decoded: a wrong bank byte goes unseen here.
    function automatic logic [15:0] sample_at(input logic [15:0] idx);
        sample_at = {1'b0, idx[6:0], 8'h5A};
    endfunction : sample_at

    assign now_out  = sample_at(addr_in[15:0]);
    assign next_out = sample_at(addr_in[15:0] + 16'h1);
endmodule : wave_mem_model
`default_nettype wire

// ===== osc_param_block_asserts.sv
// Port-level checker for the oscillator parameter block
`timescale 1ns/1ps
`default_nettype none
module osc_param_block_asserts
    import osc_param_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_b_in,
    input wire logic        ce_in,
    // Register port
    input wire logic [4:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    // Settings and stream
    input wire logic [5:0]  osc_index_in,
    input wire logic        bus_master_enable_in,
    input wire logic        sample_tick_in,
    input wire logic [23:0] wave_addr_out,
    input wire logic        host_memory_fetch_enable_out,
    input wire logic        sample_valid_out,
    // Mode decode
    input wire logic        osc_active_out,
    input wire logic        sample_width16_out,
    input wire logic        wavetable_mode_out,
    input wire logic        half_rate_out,
    input wire logic [1:0]  effect_primary_out,
    input wire logic [1:0]  effect_secondary_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    wire logic bank_wr   = ce_in && reg_wr_in && reg_addr_in == OFS_PTR_HI;
    wire logic ptr_cause = ce_in && (sample_tick_in || reg_wr_in);

    sequence tick_taken_s;
        sample_tick_in && osc_active_out && ce_in;
    endsequence
    sequence tick_refused_s;
        sample_tick_in && !osc_active_out;
    endsequence

    read_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 5'h17 |-> reg_rdata_out == 8'h00)
        else $error("offset past block end read nonzero");
    tick_answer_a: assert property (tick_taken_s |-> ##2 sample_valid_out)
        else $error("no sample two cycles after step");
    idle_tick_a: assert property (tick_refused_s |-> ##2 !sample_valid_out)
        else $error("stopped oscillator produced a sample");
    valid_cause_a: assert property (sample_valid_out |-> $past(sample_tick_in, 2))
        else $error("sample without a step");
    bank_fixed_a: assert property ($changed(wave_addr_out[23:16]) |-> $past(bank_wr))
        else $error("bank byte moved without host write");
    index_moves_a: assert property ($changed(wave_addr_out[15:0]) |-> $past(ptr_cause))
        else $error("index moved without step or write");
    fetch_route_a: assert property (host_memory_fetch_enable_out == (bus_master_enable_in && wave_addr_out[23]))
        else $error("host fetch enable wrong");
    half_limit_a: assert property (half_rate_out |-> osc_index_in < 6'h30)
        else $error("half rate on oscillator 48 or above");
    dual_wrap_a: assert property (effect_secondary_out == effect_primary_out + 2'h1)
        else $error("second effect channel wrong");
    type_decode_a: assert property ((sample_width16_out || wavetable_mode_out) |-> osc_active_out && !(sample_width16_out && wavetable_mode_out))
        else $error("type decode inconsistent");
endmodule : osc_param_block_asserts

bind osc_param_block osc_param_block_asserts checker_u (.core_clk_in, .rst_b_in, .ce_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .osc_index_in, .bus_master_enable_in,
    .sample_tick_in, .wave_addr_out, .host_memory_fetch_enable_out, .sample_valid_out,
    .osc_active_out, .sample_width16_out, .wavetable_mode_out, .half_rate_out,
    .effect_primary_out, .effect_secondary_out);
`default_nettype wire

// ===== osc_param_block_tb_top.sv
// Self-checking bench for the oscillator parameter block
`timescale 1ns/1ps
`default_nettype none
module osc_param_block_tb_top
    import osc_param_pkg::*;
;
    typedef struct packed {
        logic [7:0]  ctl, flo, fhi, eff;
        logic [5:0]  idx;
        logic [14:0] exp;
    } row_t;

    logic        core_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        ce_in = 1'b1;
    logic [4:0]  reg_addr_in = 5'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [5:0]  osc_index_in = 6'h00;
    logic        bus_master_enable_in = 1'b0;
    logic        env_flags_we_in = 1'b0;
    logic [1:0]  env_flags_in = 2'h0;
    logic        sample_tick_in = 1'b0;
    logic [15:0] sample_now_in, sample_next_in, sample_out, ptr;
    logic [23:0] wave_addr_out;
    logic [7:0]  reg_rdata_out;
    logic [3:0]  filter_q_out;
    logic [1:0]  envelope_kind_select_out, effect_primary_out, effect_secondary_out;
    logic        host_memory_fetch_enable_out, sample_valid_out, osc_active_out;
    logic        sample_width16_out, wavetable_mode_out, half_rate_out, effect_dual_out;
    int          errors = 0;
    int          n_tests = 0;
    // Expected: active, 16-bit, wavetable, half, dual, Q, envelope, primary, secondary
    row_t        rows [6] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 6'h00, 15'h0001},
        '{8'h7F, 8'h01, 8'h00, 8'h40, 6'h2F, 15'h4FD6},
        '{8'hA3, 8'h02, 8'h00, 8'h80, 6'h30, 15'h60EB},
        '{8'hC0, 8'h03, 8'h40, 8'hC0, 6'h00, 15'h503C},
        '{8'hC0, 8'h00, 8'h30, 8'h00, 6'h00, 15'h0001},
        '{8'h30, 8'h00, 8'h00, 8'hC0, 6'h05, 15'h0C0C}};

    osc_param_block dut_u (.core_clk_in, .rst_b_in, .ce_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .osc_index_in, .bus_master_enable_in,
        .env_flags_we_in, .env_flags_in, .sample_tick_in, .sample_now_in, .sample_next_in,
        .wave_addr_out, .host_memory_fetch_enable_out, .sample_out, .sample_valid_out,
        .osc_active_out, .sample_width16_out, .wavetable_mode_out, .half_rate_out,
        .filter_q_out, .envelope_kind_select_out, .effect_primary_out, .effect_secondary_out,
        .effect_dual_out);
    wave_mem_model mem_u (.addr_in(wave_addr_out), .now_out(sample_now_in),
        .next_out(sample_next_in));

    initial forever #12.5 core_clk_in = ~core_clk_in;

    // ----------
    // Tasks
    // ----------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b0;
        #1 check(reg_rdata_out, exp);
    endtask : rdc

    // Bytes 0x00-0x0B from the top; loop length bytes stay clean in wavetable mode
    task automatic load(input logic [95:0] v);
        for (int i = 0; i < 12; i++)
            wr(5'(i), v[95 - 8 * i -: 8]);
        ptr = {v[39:32], v[47:40]};
    endtask : load

    task automatic tick(input logic [15:0] nxt, input logic [15:0] frac);
        logic [15:0] a;
        logic [15:0] b;
        a = mem_u.sample_at(ptr);
        b = mem_u.sample_at(ptr + 16'h1);
        @(posedge core_clk_in);
        sample_tick_in <= 1'b1;
        @(posedge core_clk_in);
        sample_tick_in <= 1'b0;
        #1 check(wave_addr_out[15:0], nxt);
        ptr = nxt;
        @(posedge core_clk_in);
        #1 check(sample_valid_out, 1'b1);
        check(sample_out, a + 16'((32'(b - a) * frac) >> 16));
    endtask : tick

    task automatic run(input int n, input bit wt, input bit automatic_table_advance, input int s,
                       input logic [15:0] e, input logic [15:0] l);
        logic [15:0] nx;
        repeat (n)
        begin
            nx = ptr + 16'(s);
            if (wt)
                nx = (ptr[5:0] != 6'h3F || (automatic_table_advance && ptr[15:6] != e[15:6])) ? nx : e;
            else if (s > 0 && ptr <= e && nx > e)
                nx = nx - l;
            else if (s < 0 && ptr >= e && nx < e)
                nx = nx + l;
            tick(nx, 16'h0000);
        end
    endtask : run

    // ----------
    // Sequence
    // ----------
    initial
    begin
        repeat (8) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        for (int r = 0; r < 6; r++)
        begin
            osc_index_in <= rows[r].idx;
            wr(OFS_CONTROL, rows[r].ctl);
            wr(OFS_FREQ_LO, rows[r].flo);
            wr(OFS_FREQ_HI, rows[r].fhi);
            wr(OFS_EFFECT, rows[r].eff);
            #1 check({osc_active_out, sample_width16_out, wavetable_mode_out, half_rate_out,
                effect_dual_out, filter_q_out, envelope_kind_select_out, effect_primary_out,
                effect_secondary_out}, rows[r].exp);
            @(posedge core_clk_in);
            sample_tick_in <= 1'b1;
            @(posedge core_clk_in);
            sample_tick_in <= 1'b0;
            @(posedge core_clk_in);
            #1 check(sample_valid_out, rows[r].exp[14]);
            if (r == 1)
                check(sample_out, 16'h5A00);
        end
        done("modes");
        rst_b_in <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        #1 check(effect_secondary_out, 2'h1);
        for (int i = 0; i < 32; i++)
            rdc(5'(i), 8'h00);
        for (int i = 0; i < 32; i++)
            wr(5'(i), 8'(i * 7 + 1));
        for (int i = 0; i < 32; i++)
            rdc(5'(i), (i < 24) ? 8'(i * 7 + 1) : 8'h00);
        done("registers");
        bus_master_enable_in <= 1'b1;
        load(96'h81_00_00_04_00_92_00_00_07_00_03_00);
        #1 check(host_memory_fetch_enable_out, 1'b1);
        run(8, 1'b0, 1'b0, 1, 16'h0004, 16'h0003);
        check(wave_addr_out[23:16], 8'h92);
        bus_master_enable_in <= 1'b0;
        load(96'h81_00_00_FC_00_12_06_00_04_00_02_00);
        #1 check(host_memory_fetch_enable_out, 1'b0);
        run(6, 1'b0, 1'b0, -1, 16'h0004, 16'h0002);
        load(96'h81_00_00_02_00_00_10_00_FC_FF_00_00);
        tick(16'h0010, 16'h0000);
        rdc(OFS_PHASE, 8'h80);
        tick(16'h0011, 16'h8000);
        done("sample loop");
        load(96'hC1_00_00_44_00_00_3E_00_80_00_00_00);
        run(4, 1'b1, 1'b0, 1, 16'h0080, 16'h0000);
        rdc(OFS_PTR_LO, ptr[7:0]);
        load(96'hC1_00_00_44_00_00_3E_00_90_00_00_00);
        run(140, 1'b1, 1'b1, 1, 16'h0080, 16'h0000);
        done("wavetable");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk_in);
            env_flags_we_in <= 1'b1;
            env_flags_in    <= 2'(k);
            @(posedge core_clk_in);
            env_flags_we_in <= 1'b0;
            rdc(OFS_END_LO, {6'h24, 2'(k)});
        end
        // Host writes collide with an engine step, then with a flag update
        @(posedge core_clk_in);
        reg_wr_in       <= 1'b1;
        reg_addr_in     <= OFS_PTR_LO;
        reg_wdata_in    <= 8'h20;
        sample_tick_in  <= 1'b1;
        env_flags_we_in <= 1'b1;
        @(posedge core_clk_in);
        reg_addr_in     <= OFS_END_LO;
        reg_wdata_in    <= 8'h91;
        sample_tick_in  <= 1'b0;
        #1 check(wave_addr_out[15:0], 16'h0020);
        @(posedge core_clk_in);
        reg_wr_in       <= 1'b0;
        env_flags_we_in <= 1'b0;
        rdc(OFS_END_LO, 8'h91);
        done("collision");
        // Enable low must swallow a step
        @(posedge core_clk_in);
        ce_in          <= 1'b0;
        sample_tick_in <= 1'b1;
        @(posedge core_clk_in);
        ce_in          <= 1'b1;
        sample_tick_in <= 1'b0;
        #1 check(wave_addr_out[15:0], 16'h0020);
        done("enable");
        conclude();
    end

    // Whole run is under 2000 cycles; ten times that means a hang
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        errors++;
        $display("ERROR at %0t: timeout, got 0 expected 1", $time);
        conclude();
    end
endmodule : osc_param_block_tb_top
`default_nettype wire
